//--- design/recovery_timer.sv
// stop recovery timer: oscillator divider plus held-in-reset counter
module recovery_timer #(
	parameter int OSC_DIV = 1 // bus clocks per internal oscillator cycle
) (
	input  wire logic clk_i,   // bus clock
	input  wire logic rst_i,   // synchronous reset, active high
	input  wire logic hold_i,  // keep counter cleared
	input  wire logic short_i, // select short recovery
	output logic      done_o   // recovery period elapsed (level)
);
	import sysint_pkg::*;

	logic [15:0]      div_q;    // oscillator divider
	logic             osc_en;   // one pulse per oscillator cycle
	logic [CNT_W-1:0] cnt_q;    // recovery counter
	logic [CNT_W-1:0] target;   // selected recovery length

	assign osc_en = (div_q == 16'(OSC_DIV - 1));
	assign target = short_i ? STOP_SHORT : STOP_LONG;
	assign done_o = (cnt_q == target);

	// divider free-runs so oscillator cycles are steady
	always_ff @(posedge clk_i) begin
		if (rst_i || osc_en) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end

	// counter held cleared until recovery begins, then counts to target
	always_ff @(posedge clk_i) begin
		if (rst_i || hold_i) begin
			cnt_q <= '0;
		end else if (osc_en && !done_o) begin
			cnt_q <= cnt_q + 13'h0001;
		end
	end

endmodule

//--- design/sysint_break_lowpower_ctrl.sv
// system integration: irq status, resets, break handling, wait and stop
// all request inputs come from logic on the bus clock, so none of
// them passes a synchroniser; interrupt enables live upstream
//
// Register access over Wishbone is this design's own decision.
module sysint_break_lowpower_ctrl
	import sysint_pkg::*;
#(
	parameter int OSC_DIV = 1 // bus clocks per internal oscillator cycle
) (
	input  wire logic                        clk_i,            // bus clock
	input  wire logic                        rst_i,            // sync reset
	input  wire logic [sysint_pkg::ADR_W-1:0] adr_i,           // byte addr
	input  wire logic [31:0]                 dat_i,            // write data
	output logic [31:0]                      dat_o,            // read data
	input  wire logic                        we_i,             // write
	input  wire logic [3:0]                  sel_i,            // byte lanes
	input  wire logic                        cyc_i,            // bus cycle
	input  wire logic                        stb_i,            // strobe
	output logic                             ack_o,            // ack
	input  wire logic [sysint_pkg::NUM_IRQ-1:0] irq_req_i,     // src 7..17
	input  wire logic [sysint_pkg::NUM_RST-1:0] reset_req_i,   // resets
	input  wire logic                        break_irq_i,      // break req
	input  wire logic                        break_done_i,     // break exit
	input  wire logic                        wait_exec_i,      // wait instr
	input  wire logic                        stop_exec_i,      // stop instr
	output logic                             cpu_clk_en_o,     // cpu clocks
	output logic                             periph_clk_en_o,  // periph clk
	output logic                             sys_reset_o,      // reset out
	output logic                             force_swi_o,      // swi fetch
	output logic                             imask_clear_o,    // clear I
	output logic                             stack_start_o,    // stack irq
	output logic                             flag_protect_o,   // keep flags
	output logic                             break_mode_o,     // in break
	output logic                             watchdog_enable_o // wdog run
);

	// state
	lp_state_type state_q;          // low-power sequencer state
	lp_state_type state_d;          // next state
	logic         wake_break_q;     // stop exit was caused by break
	logic         wake_break_d;     // next value
	logic         stopwait_flag_q;  // break stop/wait status flag
	logic         break_clear_enable_q;           // break clear enable
	logic [7:0]   config_q;         // configuration bits
	logic         break_mode_q;     // break state
	logic         break_mode_d;     // next break state
	logic         break_clear_enable_d;           // next break clear enable

	// bus decode
	logic         bus_req;          // new access this cycle
	logic         bus_wr;           // write strobe on lane 0
	logic         hit_bsr;          // break status selected
	logic         hit_bfc;          // break flag control selected
	logic         hit_mid;          // mid irq status selected
	logic         hit_high;         // high irq status selected
	logic         hit_cfg;          // config selected
	logic         hit_lps;          // low-power status selected
	logic         stopwait_clr;     // software clear of the flag
	logic [7:0]   rd_byte;          // selected read byte

	// status and events
	logic [7:0]   pending_flags_mid;  // sources 14..7
	logic [7:0]   pending_flags_high; // sources 17..15 in low bits
	logic [7:0]   lp_status;          // low-power status byte
	logic         any_reset;          // some reset source requests
	logic         any_irq;            // some interrupt requests
	logic         rec_done;           // stop recovery elapsed
	logic         rec_hold;           // recovery counter held cleared
	logic         lowpower_exit_event; // reset, interrupt or break
	logic         set_stopwait;       // break ended wait or stop
	logic         swi_d;              // force software vector next
	logic         stack_d;            // start stacking next
	logic         mask_clr_d;         // clear interrupt mask next
	logic         cpu_en_d;           // next cpu clock enable
	logic         per_en_d;           // next peripheral clock enable

	// address decode: register index sits above the two byte bits
	assign bus_req  = cyc_i && stb_i && !ack_o;
	assign bus_wr   = bus_req && we_i && sel_i[0];
	assign hit_bsr  = (adr_i[ADR_W-1:2] == IDX_BREAK_STATUS);
	assign hit_bfc  = (adr_i[ADR_W-1:2] == IDX_BREAK_FLAG_CTRL);
	assign hit_mid  = (adr_i[ADR_W-1:2] == IDX_IRQ_MID);
	assign hit_high = (adr_i[ADR_W-1:2] == IDX_IRQ_HIGH);
	assign hit_cfg  = (adr_i[ADR_W-1:2] == IDX_CONFIG_ONE);
	assign hit_lps  = (adr_i[ADR_W-1:2] == IDX_LP_STATUS);
	// a zero written to the stop/wait bit is the software clear
	assign stopwait_clr = bus_wr && hit_bsr && !dat_i[BSW_BIT];
	// clear enable next value, so the flag guard follows a write at once
	assign break_clear_enable_d = (bus_wr && hit_bfc) ?
		dat_i[BREAK_CLEAR_ENABLE_BIT] : break_clear_enable_q;

	// pending flags track the request lines with no local latching
	// a source that drops its request clears its flag at once
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_flags
			if (gi < IRQ_MID_N) begin : g_mid
				assign pending_flags_mid[gi] = irq_req_i[gi];
			end
			if (gi < IRQ_HI_N) begin : g_hi
				assign pending_flags_high[gi] = irq_req_i[IRQ_MID_N + gi];
			end else begin : g_hi_zero
				assign pending_flags_high[gi] = 1'b0;
			end
		end
	endgenerate

	// low-power status byte
	// lets software see which low-power phase the sequencer is in
	assign lp_status = {4'h0, break_mode_q, (state_q == ST_RECOVER),
		(state_q == ST_STOP), (state_q == ST_WAIT)};

	// read multiplexer; unmapped indexes read zero
	// reads have no side effect, so break protection needs no gate here
	assign rd_byte =
		hit_bsr  ? (8'(stopwait_flag_q) << BSW_BIT) :
		hit_bfc  ? (8'(break_clear_enable_q) << BREAK_CLEAR_ENABLE_BIT) :
		hit_mid  ? pending_flags_mid :
		hit_high ? pending_flags_high :
		hit_cfg  ? config_q :
		hit_lps  ? lp_status :
		BYTE_ZERO;

	// event terms
	// any raised line wakes the core; enables are applied upstream
	assign any_reset = |reset_req_i;
	assign any_irq   = |irq_req_i;
	assign lowpower_exit_event = any_reset || any_irq || break_irq_i;
	assign rec_hold  = (state_q != ST_RECOVER);

	// break that ends wait, or arrives while stopped
	assign set_stopwait = break_irq_i &&
		((state_q == ST_WAIT) || (state_q == ST_STOP));

	// stop recovery timer
	// the short bit is read live: changing it mid-recovery moves the end
	recovery_timer #(
		.OSC_DIV (OSC_DIV)
	) u_recovery (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.hold_i  (rec_hold),
		.short_i (config_q[SHORT_STOP_RECOVERY_BIT]),
		.done_o  (rec_done)
	);

	// sequencer next state and event outputs
	// in run a break beats stop and wait executed in the same cycle, so
	// the core takes the vector fetch and the stop or wait is dropped
	always_comb begin
		state_d      = state_q;
		wake_break_d = wake_break_q;
		swi_d        = 1'b0;
		stack_d      = 1'b0;
		mask_clr_d   = 1'b0;
		if (any_reset) begin
			// resets are never arbitrated and beat every interrupt
			state_d      = ST_RUN;
			wake_break_d = 1'b0;
		end else begin
			case (state_q)
				ST_RUN: begin
					if (break_irq_i) begin
						swi_d = 1'b1;
					end else if (stop_exec_i) begin
						state_d    = ST_STOP;
						mask_clr_d = 1'b1;
					end else if (wait_exec_i) begin
						state_d    = ST_WAIT;
						mask_clr_d = 1'b1;
					end
				end
				ST_WAIT: begin
					// a break beats an irq arriving in the same cycle
					if (break_irq_i) begin
						state_d = ST_RUN;
						swi_d   = 1'b1;
					end else if (any_irq) begin
						state_d = ST_RUN;
						stack_d = 1'b1;
					end
				end
				ST_STOP: begin
					// reset was taken above, so irq or break remain
					if (lowpower_exit_event) begin
						state_d      = ST_RECOVER;
						wake_break_d = break_irq_i;
					end
				end
				ST_RECOVER: begin
					// a break mid-recovery turns the exit into a fetch
					if (break_irq_i) begin
						wake_break_d = 1'b1;
					end
					if (rec_done) begin
						state_d = ST_RUN;
						swi_d   = wake_break_q || break_irq_i;
						stack_d = !(wake_break_q || break_irq_i);
					end
				end
				default: begin
					state_d = ST_RUN;
				end
			endcase
		end
	end

	// clock gating follows the next state
	// so the enables change with the state register, not a cycle late
	assign cpu_en_d = (state_d == ST_RUN);
	assign per_en_d = (state_d == ST_RUN) ||
		(state_d == ST_WAIT);

	// sequencer registers and registered outputs
	// every output here is a flop, so the core never sees a glitch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q         <= ST_RUN;
			wake_break_q    <= 1'b0;
			cpu_clk_en_o    <= 1'b1;
			periph_clk_en_o <= 1'b1;
			sys_reset_o     <= 1'b0;
			force_swi_o     <= 1'b0;
			imask_clear_o   <= 1'b0;
			stack_start_o   <= 1'b0;
		end else begin
			state_q         <= state_d;
			wake_break_q    <= wake_break_d;
			cpu_clk_en_o    <= cpu_en_d;
			periph_clk_en_o <= per_en_d;
			sys_reset_o     <= any_reset;
			force_swi_o     <= swi_d;
			imask_clear_o   <= mask_clr_d;
			stack_start_o   <= stack_d;
		end
	end

	// break state next value: resets leave break, a new break request
	// enters it, and the break module's done pulse leaves it
	assign break_mode_d = any_reset ? 1'b0 :
		break_irq_i  ? 1'b1 :
		break_done_i ? 1'b0 :
		break_mode_q;

	// break state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			break_mode_q <= 1'b0;
		end else begin
			break_mode_q <= break_mode_d;
		end
	end

	// flag protection seen by the peripheral modules; a pending
	// two-step clear sequence is also blocked while this is high;
	// both load from next values, so they change at the same edge as
	// a vector fetch from run or wait and as a clear enable write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_protect_o <= 1'b0;
			break_mode_o   <= 1'b0;
		end else begin
			flag_protect_o <= break_mode_d && !break_clear_enable_d;
			break_mode_o   <= break_mode_d;
		end
	end

	// watchdog stays enabled through wait unless disabled in config
	// in stop and recovery its clock is gated, so it is shown stopped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			watchdog_enable_o <= 1'b0;
		end else begin
			watchdog_enable_o <= !config_q[WDD_BIT] &&
				(state_d != ST_STOP) && (state_d != ST_RECOVER);
		end
	end

	// break stop/wait flag: a new break beats a software clear
	// a reset request clears it like rst_i and wins over a set
	always_ff @(posedge clk_i) begin
		if (rst_i || any_reset) begin
			stopwait_flag_q <= 1'b0;
		end else if (set_stopwait) begin
			stopwait_flag_q <= 1'b1;
		end else if (stopwait_clr) begin
			stopwait_flag_q <= 1'b0;
		end
	end

	// writable control registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			break_clear_enable_q   <= 1'b0;
			config_q <= CONFIG_RESET;
		end else begin
			break_clear_enable_q <= break_clear_enable_d;
			if (bus_wr && hit_cfg) begin
				config_q <= dat_i[7:0];
			end
		end
	end

	// wishbone answer: ack one cycle after the request, data with it
	// bus_req masks the ack cycle, so a held strobe never counts twice
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= '0;
		end else begin
			ack_o <= bus_req;
			if (bus_req) begin
				dat_o <= {24'h00_0000, rd_byte};
			end
		end
	end

endmodule

//--- design/sysint_pkg.sv
// constants, register map and types shared by the system integration block
package sysint_pkg;

	// wishbone address width: byte address of register index is 4 * index
	localparam int ADR_W = 18;

	// register indexes (byte address = index shifted left by two)
	localparam logic [15:0] IDX_BREAK_STATUS    = 16'hFE00; // break status
	localparam logic [15:0] IDX_BREAK_FLAG_CTRL = 16'hFE03; // break flag ctl
	localparam logic [15:0] IDX_IRQ_MID         = 16'hFE05; // sources 14..7
	localparam logic [15:0] IDX_IRQ_HIGH        = 16'hFE06; // sources 17..15
	localparam logic [15:0] IDX_CONFIG_ONE      = 16'hFE09; // config bits
	localparam logic [15:0] IDX_LP_STATUS       = 16'hFE0A; // low-power state

	// field positions
	localparam int BSW_BIT   = 1; // break stop/wait flag in break status
	localparam int BREAK_CLEAR_ENABLE_BIT  = 7; // break clear enable in flag control
	localparam int SHORT_STOP_RECOVERY_BIT = 0; // short stop recovery in config
	localparam int WDD_BIT   = 1; // watchdog disable in config
	localparam int LPS_WAIT  = 0; // low-power status: in wait
	localparam int LPS_STOP  = 1; // low-power status: in stop
	localparam int LPS_REC   = 2; // low-power status: recovering
	localparam int LPS_BRK   = 3; // low-power status: break mode

	// reset values
	localparam logic [7:0] CONFIG_RESET = 8'h00; // config register reset
	localparam logic [7:0] BYTE_ZERO    = 8'h00; // zero byte

	// interrupt sources: lines 7..17, vector bit 0 is source 7
	localparam int IRQ_FIRST = 7;  // lowest source number handled
	localparam int IRQ_MID_N = 8;  // sources 14..7 in the mid register
	localparam int IRQ_HI_N  = 3;  // sources 17..15 in the high register
	localparam int NUM_IRQ   = 11; // total sources handled
	localparam int NUM_RST   = 6;  // number of reset request sources

	// stop recovery counts in internal oscillator cycles
	localparam int          CNT_W      = 13;       // recovery counter width
	localparam logic [12:0] STOP_LONG  = 13'h1000; // 4096 cycles
	localparam logic [12:0] STOP_SHORT = 13'h0020; // 32 cycles

	// low-power sequencer states
	typedef enum logic [1:0] {
		ST_RUN,
		ST_WAIT,
		ST_STOP,
		ST_RECOVER
	} lp_state_type;

endpackage

//--- verification/irq_source_model.sv
// peripheral request model: plain levels plus requests held until stacked
module irq_source_model (
	input  wire logic        clk_i,     // bus clock
	input  wire logic        rst_i,     // sync reset
	input  wire logic [10:0] level_i,   // plain level requests
	input  wire logic [10:0] raise_i,   // one-shot requests to hold
	input  wire logic        stacked_i, // core began stacking
	output logic      [10:0] irq_o      // request lines to the block
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [10:0] pend_q; // held requests awaiting service
	logic [10:0] pend_d; // next held requests
	// a request stays up until the core stacks it, as a real source does
	assign pend_d = stacked_i ? raise_i : (pend_q | raise_i);
	// held request register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend_q <= 11'h000;
		end else begin
			pend_q <= pend_d;
		end
	end
	assign irq_o = level_i | pend_q;
endmodule

//--- verification/sysint_break_lowpower_ctrl_assertions.sv
// concurrent checks on the system integration block ports
module sysint_checker #(
	parameter int OSC_DIV = 1 // bus clocks per oscillator cycle
) (
	input wire logic        clk_i,           // bus clock
	input wire logic        rst_i,           // sync reset
	input wire logic [10:0] irq_req_i,       // irq levels
	input wire logic [5:0]  reset_req_i,     // reset requests
	input wire logic        break_irq_i,     // break request
	input wire logic        wait_exec_i,     // wait executed
	input wire logic        stop_exec_i,     // stop executed
	input wire logic        cpu_clk_en_o,    // cpu clocks
	input wire logic        periph_clk_en_o, // peripheral clocks
	input wire logic        sys_reset_o,     // reset out
	input wire logic        force_swi_o,     // vector fetch
	input wire logic        imask_clear_o,   // mask clear
	input wire logic        stack_start_o,   // stacking
	input wire logic        flag_protect_o,  // flag guard
	input wire logic        break_mode_o     // break state
);
	timeunit 1ns;
	timeprecision 1ps;
	wire run_w  = cpu_clk_en_o && periph_clk_en_o && !break_mode_o; // running, not in break
	wire wait_w = !cpu_clk_en_o && periph_clk_en_o; // in wait
	wire calm_w = !break_irq_i && !(|reset_req_i); // no overriding event
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_reset_first: assert property (|reset_req_i |=> sys_reset_o
		&& !force_swi_o && !stack_start_o && !break_mode_o)
		else $error("reset request did not win");
	chk_break_swi: assert property (run_w && break_irq_i
		&& !(|reset_req_i) |=> force_swi_o && break_mode_o)
		else $error("break did not force vector fetch");
	chk_protect_brk: assert property (flag_protect_o |-> break_mode_o)
		else $error("flag guard outside break");
	chk_wait_entry: assert property (run_w && wait_exec_i
		&& !stop_exec_i && calm_w
		|=> imask_clear_o && !cpu_clk_en_o && periph_clk_en_o)
		else $error("wait entry wrong");
	chk_wait_wake: assert property (wait_w && |irq_req_i && calm_w
		|=> stack_start_o && cpu_clk_en_o)
		else $error("irq did not wake from wait");
	chk_wait_break: assert property (wait_w && break_irq_i
		&& !(|reset_req_i) && !(|irq_req_i)
		|=> force_swi_o ##0 cpu_clk_en_o ##0 break_mode_o)
		else $error("break did not end wait");
	chk_stop_gate: assert property (run_w && stop_exec_i && calm_w
		|=> !cpu_clk_en_o && !periph_clk_en_o && imask_clear_o)
		else $error("stop did not gate clocks");
	chk_stop_exit: assert property ($rose(periph_clk_en_o)
		|-> stack_start_o || force_swi_o || sys_reset_o)
		else $error("stop ended without cause");
	cover property (wait_w ##1 stack_start_o);
	cover property (!periph_clk_en_o ##1 force_swi_o);
	cover property ($rose(flag_protect_o));
endmodule
bind sysint_break_lowpower_ctrl sysint_checker #(.OSC_DIV(OSC_DIV)) chk_u (
	.clk_i(clk_i), .rst_i(rst_i), .irq_req_i(irq_req_i),
	.reset_req_i(reset_req_i), .break_irq_i(break_irq_i),
	.wait_exec_i(wait_exec_i), .stop_exec_i(stop_exec_i),
	.cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
	.sys_reset_o(sys_reset_o), .force_swi_o(force_swi_o),
	.imask_clear_o(imask_clear_o), .stack_start_o(stack_start_o),
	.flag_protect_o(flag_protect_o), .break_mode_o(break_mode_o));

//--- verification/sysint_break_lowpower_ctrl_tb.sv
// self-checking bench for the system integration block
module sysint_break_lowpower_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sysint_pkg::*;
	logic        clk_i = 1'h0, rst_i = 1'h1, we_i = 1'h0, ack_o;
	logic        cyc_i = 1'h0, stb_i = 1'h0;
	logic [17:0] adr_i = 18'h0_0000;
	logic [31:0] dat_i = 32'h0000_0000, dat_o;
	logic [3:0]  sel_i = 4'h1;
	logic [3:0]  ev_q = 4'h0; // stop, wait, done, break pulses
	logic [10:0] level_q = 11'h000, raise_q = 11'h000, irq_w;
	logic [5:0]  rreq_q = 6'h00; // reset requests
	logic        cpu_en, per_en, srst, software_interrupt_vector, imc, stk, prot, bmode, wdog;
	logic [7:0]  rd;
	int          error_cnt = 0, n_checks = 0, cyc_cnt = 0, n;
	always #25 clk_i = ~clk_i;
	irq_source_model src_u (.clk_i(clk_i), .rst_i(rst_i),
		.level_i(level_q), .raise_i(raise_q), .stacked_i(stk),
		.irq_o(irq_w));
	sysint_break_lowpower_ctrl #(.OSC_DIV(1)) uut (.clk_i(clk_i),
		.rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
		.we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.ack_o(ack_o), .irq_req_i(irq_w), .reset_req_i(rreq_q),
		.break_irq_i(ev_q[0]), .break_done_i(ev_q[1]),
		.wait_exec_i(ev_q[2]), .stop_exec_i(ev_q[3]),
		.cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en),
		.sys_reset_o(srst), .force_swi_o(software_interrupt_vector), .imask_clear_o(imc),
		.stack_start_o(stk), .flag_protect_o(prot),
		.break_mode_o(bmode), .watchdog_enable_o(wdog));
	// recovery length in oscillator ticks for the short setting
	function automatic int rec_len(input int s);
		return s ? 32 : 4096;
	endfunction
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one classic cycle; held until ack is sampled high
	task automatic wb(input logic wr, input logic [15:0] idx,
		input logic [7:0] wd);
		int k;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i} <= {2'h3, wr};
		adr_i <= {idx, 2'h0};
		dat_i <= {24'h00_0000, wd};
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'h1 && k < 20);
		rd = dat_o[7:0];
		{cyc_i, stb_i, we_i} <= 3'h0;
		if (k >= 20) error_cnt++;
	endtask
	// one-cycle event pulse, then let the answer settle
	task automatic pulse(input logic [3:0] m);
		@(posedge clk_i);
		ev_q <= m;
		@(posedge clk_i);
		ev_q <= 4'h0;
		#1;
	endtask
	// one-shot peripheral request, settled one edge after it is seen
	task automatic fire(input logic [10:0] m);
		@(posedge clk_i);
		raise_q <= m;
		@(posedge clk_i);
		raise_q <= 11'h000;
		@(posedge clk_i);
		#1;
	endtask
	// hang guard
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt > 20000) begin
			error_cnt++;
			give_verdict();
		end
	end
	initial begin
		void'($urandom(32'h835a));
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		wb(0, IDX_CONFIG_ONE, 8'h00);
		check("config", rd, 8'h00);
		wb(0, IDX_BREAK_FLAG_CTRL, 8'h00);
		check("clear enable", rd, 8'h00);
		wb(1, 16'hFE01, 8'hFF);
		wb(0, 16'hFE01, 8'h00);
		check("unmapped", rd, 8'h00);
		$display("reset values done");
		repeat (6) begin
			level_q <= 11'($urandom);
			wb(1, IDX_IRQ_MID, 8'($urandom));
			wb(0, IDX_IRQ_MID, 8'h00);
			check("mid flags", rd, level_q[7:0]);
			wb(0, IDX_IRQ_HIGH, 8'h00);
			check("high flags", rd, {5'h00, level_q[10:8]});
		end
		level_q <= 11'h000;
		$display("status flags done");
		pulse(4'h4);
		check("wait clocks", {cpu_en, per_en, imc, wdog}, 4'h7);
		fire(11'h400);
		check("wait wake", {stk, cpu_en}, 2'h3);
		wb(1, IDX_CONFIG_ONE, 8'h02);
		@(posedge clk_i);
		#1;
		check("watchdog off", wdog, 1'h0);
		$display("wait done");
		for (int s = 1; s >= 0; s--) begin
			wb(1, IDX_CONFIG_ONE, 8'(s));
			pulse(4'h8);
			check("stop gate", {cpu_en, per_en, imc}, 3'h1);
			wb(0, IDX_LP_STATUS, 8'h00);
			check("lp status", rd, 8'(1) << LPS_STOP);
			fire(11'($urandom) | 11'h001);
			n = 2;
			while (stk !== 1'h1 && n < 5000) begin
				@(posedge clk_i);
				#1;
				n++;
			end
			check("recovery", n >= rec_len(s) && n <= rec_len(s) + 4,
				1'h1);
		end
		$display("stop done");
		pulse(4'h1);
		check("break from run", {software_interrupt_vector, bmode}, 2'h3);
		pulse(4'h2);
		pulse(4'h4);
		pulse(4'h1);
		check("break in wait", {software_interrupt_vector, bmode, prot}, 3'h7);
		wb(0, IDX_BREAK_STATUS, 8'h00);
		check("stop wait flag", rd[BSW_BIT], 1'h1);
		wb(1, IDX_BREAK_FLAG_CTRL, 8'h80);
		wb(0, IDX_BREAK_FLAG_CTRL, 8'h00);
		check("clear enable rw", rd, 8'h80);
		check("guard off", prot, 1'h0);
		wb(1, IDX_BREAK_STATUS, 8'h00);
		wb(0, IDX_BREAK_STATUS, 8'h00);
		check("flag cleared", rd[BSW_BIT], 1'h0);
		pulse(4'h2);
		wb(1, IDX_CONFIG_ONE, 8'h01);
		pulse(4'h8);
		pulse(4'h1);
		n = 0;
		while (software_interrupt_vector !== 1'h1 && n < 200) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		wb(0, IDX_BREAK_STATUS, 8'h00);
		check("break in stop", rd[BSW_BIT], 1'h1);
		@(posedge clk_i);
		rreq_q <= 6'($urandom) | 6'h01;
		@(posedge clk_i);
		rreq_q <= 6'h00;
		#1;
		check("reset out", {srst, software_interrupt_vector, stk}, 3'h4);
		wb(0, IDX_BREAK_STATUS, 8'h00);
		check("flag after reset", rd[BSW_BIT], 1'h0);
		$display("break done");
		give_verdict();
	end
endmodule
